// File: hw/sbc_pkg.sv
package sbc_pkg;
   localparam logic [6:0] ADDR_SUPPLY  = 7'h41;
   localparam logic [6:0] ADDR_THERMAL = 7'h42;
   localparam logic [6:0] ADDR_DEVICE  = 7'h43;
   localparam int FRAME_BITS  = 16;
   localparam int MODE_BIT    = 7;
   localparam int DATA_LSB    = 8;
   localparam logic [7:0] SUPPLY_RESET  = 8'h80;
   localparam logic [7:0] THERMAL_RESET = 8'h00;
   localparam logic [7:0] DEVICE_RESET  = 8'h00;
   localparam logic [7:0] SUPPLY_MASK   = 8'hFD;
   localparam logic [7:0] THERMAL_MASK  = 8'h07;
   localparam logic [1:0] CAUSE_CLEARED = 2'h0;
   localparam logic [1:0] CAUSE_FAILURE = 2'h1;
   localparam logic [1:0] CAUSE_SLEEP   = 2'h2;
   localparam logic [1:0] WDC_MAX       = 2'h2;
   typedef enum logic [1:0] {
      SBC_IDLE   = 2'b00,
      SBC_ANSWER = 2'b01
   } sbc_state_t;
endpackage

// File: hw/sbc_frame_if.sv
`timescale 1ns/1ns
interface sbc_frame_if;
   logic       req;
   logic       clear;
   logic [6:0] addr;
   modport dec (output req, output clear, output addr);
   modport bank (input req, input clear, input addr);
endinterface

// File: hw/sbc_frame_decode.sv
`timescale 1ns/1ns
module sbc_frame_decode
   import sbc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        frame_valid,
   input  wire logic [15:0] frame_in,
   sbc_frame_if.dec         fr
);
   // frame bits 6:0 address, bit 7 mode; data byte ignored for status
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fr.req   <= 1'b0;
         fr.clear <= 1'b0;
         fr.addr  <= 7'h00;
      end else begin
         fr.req   <= frame_valid;
         fr.clear <= frame_in[MODE_BIT];
         fr.addr  <= frame_in[6:0];
      end
   end
endmodule

// File: hw/sbc_status_bank.sv
`timescale 1ns/1ns
module sbc_status_bank
   import sbc_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // frame port
   input  wire logic        frame_valid,
   input  wire logic [15:0] frame_in,
   output logic             reply_valid,
   output logic [15:0]      reply_frame,
   // detector events (one-cycle or level)
   input  wire logic        por_event,
   input  wire logic        lin_uv_event,
   input  wire logic        main_ov_event,
   input  wire logic        second_ot_event,
   input  wire logic        second_uv_event,
   input  wire logic        main_short_event,
   input  wire logic        main_uv_event,
   input  wire logic        shutdown2_event,
   input  wire logic        shutdown1_event,
   input  wire logic        prewarn_event,
   input  wire logic        reset_clamp_event,
   input  wire logic        fsi_fault_event,
   input  wire logic        invalid_cmd_event,
   // supply and mode context
   input  wire logic        main_reg_on,
   input  wire logic        second_reg_on,
   input  wire logic        lin_active,
   input  wire logic        overvoltage_reset_enable,
   // restart and watchdog
   input  wire logic        restart_event,
   input  wire logic        restart_from_sleep,
   input  wire logic        watchdog_failure_counter_event,
   input  wire logic        wd_trigger_ok,
   input  wire logic        fail_outputs_on,
   // outputs
   output logic             failsafe_request,
   output logic [1:0]       fail_output_config
);
   // ==========================================================
   // frame decode
   sbc_frame_if fr ();
   sbc_frame_decode u_dec (
      .clk         (clk),
      .reset_n     (reset_n),
      .frame_valid (frame_valid),
      .frame_in    (frame_in),
      .fr          (fr)
   );

   logic [7:0] supply_fault_status;
   logic [7:0] thermal_fault_status;
   logic [1:0] restart_cause_field;
   logic       reset_clamped_high_flag;
   logic       failsafe_input_fault_flag;
   logic [1:0] watchdog_failure_counter;
   logic       invalid_cmd_flag;
   logic       fail_outputs_active_flag;
   logic       failure_seen;

   wire clr_sup = fr.req && fr.clear && fr.addr == ADDR_SUPPLY;
   wire clr_thm = fr.req && fr.clear && fr.addr == ADDR_THERMAL;
   wire clr_dev = fr.req && fr.clear && fr.addr == ADDR_DEVICE;

   // ==========================================================
   // supply status
   logic [7:0] sup_set;
   always_comb begin
      sup_set    = 8'h00;
      sup_set[7] = por_event;
      sup_set[6] = lin_uv_event && lin_active;
      sup_set[5] = main_ov_event;
      sup_set[4] = second_ot_event && second_reg_on;
      sup_set[3] = second_uv_event && second_reg_on;
      sup_set[2] = main_short_event && main_reg_on;
      sup_set[0] = main_uv_event && main_reg_on;
   end

   // sticky; set beats clear
   always_ff @(posedge clk) begin
      if (!reset_n) supply_fault_status <= SUPPLY_RESET;
      else supply_fault_status <= ((clr_sup ? 8'h00 : supply_fault_status) | sup_set)
                                  & SUPPLY_MASK;
   end

   // ==========================================================
   // thermal status
   wire [7:0] thm_set = {5'h00, shutdown2_event, shutdown1_event, prewarn_event};
   always_ff @(posedge clk) begin
      if (!reset_n) thermal_fault_status <= THERMAL_RESET;
      else thermal_fault_status <= ((clr_thm ? 8'h00 : thermal_fault_status) | thm_set)
                                   & THERMAL_MASK;
   end

   // level-2 shutdown forces fail-safe, held until reset
   always_ff @(posedge clk) begin
      if (!reset_n) failsafe_request <= 1'b0;
      else if (shutdown2_event) failsafe_request <= 1'b1;
   end

   // ==========================================================
   // device status
   // a failure is remembered until the next restart records the cause
   always_ff @(posedge clk) begin
      if (!reset_n) failure_seen <= 1'b0;
      else if (watchdog_failure_counter_event || shutdown2_event || main_uv_event
               || (main_ov_event && overvoltage_reset_enable)) failure_seen <= 1'b1;
      else if (restart_event) failure_seen <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) restart_cause_field <= CAUSE_CLEARED;
      else if (restart_event)
         restart_cause_field <= restart_from_sleep && !failure_seen ? CAUSE_SLEEP
                                                                     : CAUSE_FAILURE;
      else if (clr_dev) restart_cause_field <= CAUSE_CLEARED;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         reset_clamped_high_flag   <= 1'b0;
         failsafe_input_fault_flag <= 1'b0;
         invalid_cmd_flag          <= 1'b0;
         fail_outputs_active_flag  <= 1'b0;
      end else begin
         reset_clamped_high_flag   <= reset_clamp_event | (reset_clamped_high_flag & ~clr_dev);
         failsafe_input_fault_flag <= fsi_fault_event | (failsafe_input_fault_flag & ~clr_dev);
         invalid_cmd_flag          <= invalid_cmd_event | (invalid_cmd_flag & ~clr_dev);
         fail_outputs_active_flag  <= fail_outputs_on | (fail_outputs_active_flag & ~clr_dev);
      end
   end

   // counter is hardware-owned: clear frames do not touch it
   always_ff @(posedge clk) begin
      if (!reset_n) watchdog_failure_counter <= 2'h0;
      else if (watchdog_failure_counter_event && watchdog_failure_counter != WDC_MAX)
         watchdog_failure_counter <= watchdog_failure_counter + 2'h1;
      else if (wd_trigger_ok) watchdog_failure_counter <= 2'h0;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) fail_output_config <= 2'h0;
      else fail_output_config <= watchdog_failure_counter;
   end

   wire [7:0] dev_byte = {restart_cause_field, reset_clamped_high_flag,
                          failsafe_input_fault_flag, watchdog_failure_counter,
                          invalid_cmd_flag, fail_outputs_active_flag};

   // ==========================================================
   // reply: value before any clear of this frame
   logic [7:0] rd_byte;
   always_comb begin
      case (fr.addr)
         ADDR_SUPPLY:  rd_byte = supply_fault_status;
         ADDR_THERMAL: rd_byte = thermal_fault_status;
         ADDR_DEVICE:  rd_byte = dev_byte;
         default:      rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         reply_valid <= 1'b0;
         reply_frame <= 16'h0000;
      end else begin
         reply_valid <= fr.req;
         if (fr.req) reply_frame <= {rd_byte, fr.clear, fr.addr};
      end
   end

   // ==========================================================
   // checks
   a_read_keeps_flags: assert property (@(posedge clk) disable iff (!reset_n)
      fr.req && !fr.clear && fr.addr == ADDR_THERMAL |=> (thermal_fault_status
      & $past(thermal_fault_status)) == $past(thermal_fault_status))
      else $error("read altered thermal flags");
   a_clear_empties: assert property (@(posedge clk) disable iff (!reset_n)
      clr_thm && !shutdown2_event && !shutdown1_event && !prewarn_event
      |=> thermal_fault_status == 8'h00) else $error("thermal clear failed");
   a_set_wins_clear: assert property (@(posedge clk) disable iff (!reset_n)
      clr_sup && main_ov_event |=> supply_fault_status[5]) else $error("event lost");
   a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
      supply_fault_status[1] == 1'b0 && thermal_fault_status[7:3] == 5'h00)
      else $error("reserved bit set");
   a_main_off_quiet: assert property (@(posedge clk) disable iff (!reset_n)
      !main_reg_on && !supply_fault_status[0] |=> !supply_fault_status[0])
      else $error("uv flag set with regulator off");
   a_wdc_limit: assert property (@(posedge clk) disable iff (!reset_n)
      watchdog_failure_counter != 2'h3) else $error("wd counter reached 3");
   a_wdc_clear: assert property (@(posedge clk) disable iff (!reset_n)
      wd_trigger_ok && !watchdog_failure_counter_event |=> watchdog_failure_counter == 2'h0)
      else $error("wd counter not cleared");
   a_shutdown_failsafe: assert property (@(posedge clk) disable iff (!reset_n)
      shutdown2_event |=> failsafe_request && thermal_fault_status[2])
      else $error("level-2 shutdown missed");
   a_spi_flag_hold: assert property (@(posedge clk) disable iff (!reset_n)
      invalid_cmd_flag && !clr_dev |=> invalid_cmd_flag) else $error("flag dropped");
   a_reply_byte: assert property (@(posedge clk) disable iff (!reset_n)
      fr.req && fr.addr == ADDR_DEVICE |=> reply_frame[15:8] == $past(dev_byte))
      else $error("reply byte wrong");

   // ==========================================================
   // frame pipeline checks
   // decode takes one edge, the reply a second one
   sequence s_frame_pipe;
      fr.req ##1 reply_valid;
   endsequence

   a_reply_timing: assert property (@(posedge clk) disable iff (!reset_n)
      frame_valid |=> s_frame_pipe)
      else $error("reply not two edges after frame");
   a_reply_pulse: assert property (@(posedge clk) disable iff (!reset_n)
      reply_valid == $past(fr.req))
      else $error("reply strobe without frame");
   a_reply_echo: assert property (@(posedge clk) disable iff (!reset_n)
      fr.req |=> reply_frame[7:0] == {$past(fr.clear), $past(fr.addr)})
      else $error("reply echo wrong");
   a_unmapped_zero: assert property (@(posedge clk) disable iff (!reset_n)
      fr.req && (fr.addr < ADDR_SUPPLY || fr.addr > ADDR_DEVICE)
      |=> reply_frame[15:8] == 8'h00)
      else $error("unmapped address gave data");

   // ==========================================================
   // supply and thermal flag checks
   // a quiet clear is one with no supply flag set by an event in the same cycle
   sequence s_clear_sup;
      clr_sup && sup_set == 8'h00;
   endsequence

   a_sup_clear_empties: assert property (@(posedge clk) disable iff (!reset_n)
      s_clear_sup |=> supply_fault_status == 8'h00)
      else $error("supply clear failed");
   a_sup_hold: assert property (@(posedge clk) disable iff (!reset_n)
      !clr_sup |=> (supply_fault_status & $past(supply_fault_status))
      == $past(supply_fault_status))
      else $error("supply flag dropped");
   a_thm_hold: assert property (@(posedge clk) disable iff (!reset_n)
      !clr_thm |=> (thermal_fault_status & $past(thermal_fault_status))
      == $past(thermal_fault_status))
      else $error("thermal flag dropped");
   a_sup_events: assert property (@(posedge clk) disable iff (!reset_n)
      |sup_set |=> (supply_fault_status & $past(sup_set)) == $past(sup_set))
      else $error("supply event lost");
   a_thm_events: assert property (@(posedge clk) disable iff (!reset_n)
      |thm_set |=> (thermal_fault_status & $past(thm_set)) == $past(thm_set))
      else $error("thermal event lost");
   a_por_sets: assert property (@(posedge clk) disable iff (!reset_n)
      por_event |=> supply_fault_status[7])
      else $error("power-on flag missed");
   a_lin_off_quiet: assert property (@(posedge clk) disable iff (!reset_n)
      !lin_active && !supply_fault_status[6] |=> !supply_fault_status[6])
      else $error("lin flag set while lin idle");
   a_second_off_quiet: assert property (@(posedge clk) disable iff (!reset_n)
      !second_reg_on && supply_fault_status[4:3] == 2'b00
      |=> supply_fault_status[4:3] == 2'b00)
      else $error("second regulator flag set while off");
   a_short_off_quiet: assert property (@(posedge clk) disable iff (!reset_n)
      !main_reg_on && !supply_fault_status[2] |=> !supply_fault_status[2])
      else $error("short flag set with regulator off");
   a_failsafe_holds: assert property (@(posedge clk) disable iff (!reset_n)
      failsafe_request |=> failsafe_request)
      else $error("fail-safe request dropped");

   // ==========================================================
   // device status checks
   sequence s_clear_dev_quiet;
      clr_dev && !restart_event && !reset_clamp_event && !fsi_fault_event
      && !invalid_cmd_event && !fail_outputs_on;
   endsequence

   sequence s_wd_step;
      watchdog_failure_counter_event && watchdog_failure_counter != WDC_MAX;
   endsequence

   sequence s_restart_fail;
      restart_event && failure_seen;
   endsequence

   a_dev_clear_empties: assert property (@(posedge clk) disable iff (!reset_n)
      s_clear_dev_quiet |=> dev_byte[7:4] == 4'h0 && dev_byte[1:0] == 2'h0)
      else $error("device clear failed");
   a_dev_flags_hold: assert property (@(posedge clk) disable iff (!reset_n)
      !clr_dev |=> ({reset_clamped_high_flag, failsafe_input_fault_flag,
      invalid_cmd_flag, fail_outputs_active_flag}
      & $past({reset_clamped_high_flag, failsafe_input_fault_flag,
      invalid_cmd_flag, fail_outputs_active_flag}))
      == $past({reset_clamped_high_flag, failsafe_input_fault_flag,
      invalid_cmd_flag, fail_outputs_active_flag}))
      else $error("device flag dropped");
   a_clamp_sets: assert property (@(posedge clk) disable iff (!reset_n)
      reset_clamp_event |=> reset_clamped_high_flag)
      else $error("clamp flag missed");
   a_fsi_sets: assert property (@(posedge clk) disable iff (!reset_n)
      fsi_fault_event |=> failsafe_input_fault_flag)
      else $error("fail-safe input flag missed");
   a_invalid_sets: assert property (@(posedge clk) disable iff (!reset_n)
      invalid_cmd_event |=> invalid_cmd_flag)
      else $error("invalid command flag missed");
   a_fo_sets: assert property (@(posedge clk) disable iff (!reset_n)
      fail_outputs_on |=> fail_outputs_active_flag)
      else $error("fail output flag missed");
   // the counter belongs to the watchdog, so a clear frame must leave it
   a_clear_keeps_wdc: assert property (@(posedge clk) disable iff (!reset_n)
      clr_dev && !wd_trigger_ok && !watchdog_failure_counter_event |=> $stable(watchdog_failure_counter))
      else $error("clear frame touched wd counter");
   a_wdc_step: assert property (@(posedge clk) disable iff (!reset_n)
      s_wd_step |=> watchdog_failure_counter == $past(watchdog_failure_counter) + 2'h1)
      else $error("wd counter did not count");
   a_wdc_saturate: assert property (@(posedge clk) disable iff (!reset_n)
      watchdog_failure_counter_event && !wd_trigger_ok && watchdog_failure_counter == WDC_MAX
      |=> watchdog_failure_counter == WDC_MAX)
      else $error("wd counter left its limit");
   a_fail_config: assert property (@(posedge clk) disable iff (!reset_n)
      fail_output_config == $past(watchdog_failure_counter))
      else $error("fail output config wrong");
   a_restart_fail: assert property (@(posedge clk) disable iff (!reset_n)
      s_restart_fail |=> restart_cause_field == CAUSE_FAILURE)
      else $error("failure restart not recorded");
   a_restart_sleep: assert property (@(posedge clk) disable iff (!reset_n)
      restart_event && restart_from_sleep && !failure_seen
      |=> restart_cause_field == CAUSE_SLEEP)
      else $error("sleep wake not recorded");
   a_cause_unused: assert property (@(posedge clk) disable iff (!reset_n)
      restart_cause_field != 2'h3)
      else $error("unused restart cause");
   a_cause_clear: assert property (@(posedge clk) disable iff (!reset_n)
      clr_dev && !restart_event |=> restart_cause_field == CAUSE_CLEARED)
      else $error("restart cause not cleared");
   a_cause_hold: assert property (@(posedge clk) disable iff (!reset_n)
      !clr_dev && !restart_event |=> $stable(restart_cause_field))
      else $error("restart cause changed by itself");
endmodule

// File: test/sbc_host_model.sv
`timescale 1ns/1ns
module sbc_host_model (
   // clock
   input  wire logic        clk,
   // frame port of the bank
   output logic             frame_valid,
   output logic [15:0]      frame_in,
   input  wire logic        reply_valid,
   input  wire logic [15:0] reply_frame
);
   logic [7:0] junk;

   initial begin
      frame_valid = 1'b0;
      frame_in    = 16'hFFFF;
      junk        = 8'h5A;
   end

   // ========================================
   // frame access
   // the data byte is noise: the bank must ignore it on status places
   task automatic xfer(input logic [6:0] a, input logic clr,
                       output logic [15:0] r, output logic hung);
      hung = 1'b1;
      r    = 16'h0000;
      junk = {junk[6:0], junk[7] ^ junk[3]};
      frame_valid <= 1'b1;
      frame_in    <= {junk, clr, a};
      @(posedge clk);
      frame_valid <= 1'b0;
      frame_in    <= ~frame_in;
      for (int i = 0; i < 8 && hung; i++) begin
         @(negedge clk);
         if (reply_valid === 1'b1) begin
            r    = reply_frame;
            hung = 1'b0;
         end
      end
      @(posedge clk);
   endtask
endmodule

// File: test/tb.sv
`timescale 1ns/1ns
module tb
   import sbc_pkg::*;
;
   // ========================================
   // signals
   logic        clk;
   logic        reset_n;
   logic [16:0] ev;
   logic [4:0]  ctx;
   logic        frame_valid;
   logic [15:0] frame_in;
   logic        reply_valid;
   logic [15:0] reply_frame;
   logic        failsafe_request;
   logic [1:0]  fail_output_config;
   int          n_mismatch;
   int          samples_checked;

   sbc_status_bank sbc_status_bank_inst (
      .clk(clk), .reset_n(reset_n), .frame_valid(frame_valid), .frame_in(frame_in),
      .reply_valid(reply_valid), .reply_frame(reply_frame),
      .por_event(ev[0]), .lin_uv_event(ev[1]), .main_ov_event(ev[2]),
      .second_ot_event(ev[3]), .second_uv_event(ev[4]), .main_short_event(ev[5]),
      .main_uv_event(ev[6]), .shutdown2_event(ev[7]), .shutdown1_event(ev[8]),
      .prewarn_event(ev[9]),
      .reset_clamp_event(ev[10]), .fsi_fault_event(ev[11]), .invalid_cmd_event(ev[12]),
      .main_reg_on(ctx[0]), .second_reg_on(ctx[1]), .lin_active(ctx[2]),
      .overvoltage_reset_enable(ctx[3]), .restart_from_sleep(ctx[4]),
      .restart_event(ev[13]), .watchdog_failure_counter_event(ev[14]), .wd_trigger_ok(ev[15]),
      .fail_outputs_on(ev[16]), .failsafe_request(failsafe_request),
      .fail_output_config(fail_output_config));

   sbc_host_model sbc_host_model_inst (.clk(clk), .frame_valid(frame_valid),
      .frame_in(frame_in), .reply_valid(reply_valid), .reply_frame(reply_frame));

   // ========================================
   // tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // the reply echoes mode and address below the status byte
   task automatic rd(input logic [6:0] a, input logic clr, input logic [7:0] exp);
      logic [15:0] r;
      logic        hung;
      sbc_host_model_inst.xfer(a, clr, r, hung);
      if (hung) begin
         n_mismatch++;
         $display("[ERR] %0t: no reply", $time);
         end_of_test();
      end else begin
         chk(r, {exp, clr, a});
      end
   endtask

   task automatic pulse(input logic [16:0] m);
      ev <= m;
      @(posedge clk);
      ev <= '0;
      @(posedge clk);
   endtask

   // ========================================
   // sequence
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      n_mismatch      = 0;
      samples_checked = 0;
      reset_n         = 1'b0;
      ev              = '0;
      ctx             = 5'h07;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd(ADDR_SUPPLY, 1'b0, 8'h80);
      rd(ADDR_SUPPLY, 1'b0, 8'h80);
      rd(ADDR_SUPPLY, 1'b1, 8'h80);
      rd(ADDR_SUPPLY, 1'b0, 8'h00);
      rd(ADDR_THERMAL, 1'b0, 8'h00);
      rd(ADDR_DEVICE, 1'b0, 8'h00);
      $display("test reset values done");
      pulse(17'h003FF);
      rd(ADDR_SUPPLY, 1'b0, 8'hFD);
      rd(ADDR_THERMAL, 1'b1, 8'h07);
      chk({15'h0000, failsafe_request}, 16'h0001);
      rd(ADDR_SUPPLY, 1'b1, 8'hFD);
      rd(ADDR_THERMAL, 1'b0, 8'h00);
      ctx <= 5'h00;
      pulse(17'h0007A);
      rd(ADDR_SUPPLY, 1'b0, 8'h00);
      ctx <= 5'h07;
      rd(7'h44, 1'b1, 8'h00);
      $display("test supply and thermal done");
      pulse(17'h11C00);
      repeat (3) pulse(17'h04000);
      pulse(17'h02000);
      chk({14'h0000, fail_output_config}, 16'h0002);
      rd(ADDR_DEVICE, 1'b0, 8'h7B);
      rd(ADDR_DEVICE, 1'b1, 8'h7B);
      rd(ADDR_DEVICE, 1'b0, 8'h08);
      pulse(17'h08000);
      rd(ADDR_DEVICE, 1'b0, 8'h00);
      ctx <= 5'h17;
      pulse(17'h00004);
      pulse(17'h02000);
      rd(ADDR_DEVICE, 1'b1, 8'h80);
      ctx <= 5'h1F;
      pulse(17'h00004);
      pulse(17'h02000);
      rd(ADDR_DEVICE, 1'b1, 8'h40);
      $display("test device status done");
      // the event lands on the very edge at which the clear takes effect
      fork
         rd(ADDR_THERMAL, 1'b1, 8'h00);
         begin
            repeat (1) @(posedge clk);
            ev <= 17'h00200;
            @(posedge clk);
            ev <= '0;
         end
      join
      rd(ADDR_THERMAL, 1'b0, 8'h01);
      $display("test set over clear done");
      end_of_test();
   end
endmodule
